// ==== logic/sarbi_map.vh ====
// Register offsets, field positions, reset values and timing counts for the converter interface.
`ifndef SARBI_MAP_VH
`define SARBI_MAP_VH
`define SARBI_OFF_CTRL      5'h00
`define SARBI_OFF_STATUS    5'h04
`define SARBI_OFF_RESULT    5'h08
`define SARBI_OFF_IRQ_STAT  5'h0C
`define SARBI_OFF_IRQ_EN    5'h10
`define SARBI_OFF_IRQ_CLR   5'h14
`define SARBI_CTRL_STRAP    0
`define SARBI_CTRL_RESET    1'h0
`define SARBI_HALF_SCALE    12'h800
`define SARBI_TRIAL_NS      500
`define SARBI_CLK_NS        100
`define SARBI_TRIAL_CYC     ((`SARBI_TRIAL_NS) / (`SARBI_CLK_NS))
`define SARBI_RESP_OKAY     2'h0
`define SARBI_RESP_SLVERR   2'h2
`endif

// ==== logic/sarbi_top.v ====
// Control, result latch and three-state output logic of a successive-approximation converter.
// Summary of operation
// - Host operations happen only while the active-low chip select is low.
// - Host operations happen only while chip enable is high.
// - Read/convert low starts a conversion; high reads the latched result.
// - Short-cycle level at start picks 12-bit (low) or 8-bit (high) conversion.
// - Byte mode: short-cycle 0 gives 8 MSBs, 1 gives 4 LSBs and zeros.
// - Word mode drives the full 12-bit result on all data outputs.
// - Short-cycle may change during a read; the driven byte follows it.
// - Start at half scale, keep or clear each trial bit, walk downward.
// - After the last trial the approximation is copied to the output buffers.
// - Result is valid only after conversion end, which the busy flag shows.
// - High byte carries bits 11..4; low byte bits 3..0 then four zeros.
// - Busy flag is high for the whole conversion and low once latched.
// - Start commands during a conversion are ignored.
`include "sarbi_map.vh"
module sarbi_top #(
  parameter TRIAL_CYC = `SARBI_TRIAL_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        chip_sel_n,
  input  wire        chip_en,
  input  wire        read_conv,
  input  wire        byte_short_cycle_sel,
  input  wire        comp_above,
  output reg  [11:0] trial_level,
  output reg  [11:0] result_bus,
  output wire [11:0] result_bus_oe,
  output reg         conversion_busy_flag,
  output wire        irq,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [31:0] TRIAL_LAST = TRIAL_CYC - 1;
  localparam [3:0]  MSB_IDX    = 4'hB;
  localparam [3:0]  LSB_FULL   = 4'h0;
  localparam [3:0]  LSB_SHORT  = 4'h4;

  // Reports whether a byte address falls on the word of a register offset.
  function reg_hit;
    input [4:0] addr;
    input [4:0] offset;
    begin
      reg_hit = (addr[4:2] == offset[4:2]);
    end
  endfunction

  // Returns the approximation with one trial bit settled by the comparator.
  function [11:0] settle_bit;
    input [11:0] level;
    input [3:0]  idx;
    input        keep;
    reg   [11:0] mask;
    begin
      mask       = 12'h001 << idx;
      settle_bit = keep ? level : (level & ~mask);
    end
  endfunction


  reg  [11:0] result_reg;
  reg  [3:0]  bit_idx_reg;
  reg  [3:0]  last_idx_reg;
  reg  [15:0] wait_cnt_reg;
  reg         word_mode_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_en_reg;
  reg         selected_d_reg;
  reg  [4:0]  awaddr_reg;
  reg         aw_held_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         w_held_reg;
  wire        selected;
  wire        start_cmd;
  wire        read_cmd;
  wire        trial_done;
  wire        conv_end;
  wire        do_write;
  wire [4:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  reg  [11:0] out_value;
  wire        hit_ctrl;
  wire        hit_irq_en;
  wire        hit_irq_clr;
  wire [1:0]  irq_clr_bits;
  wire [1:0]  irq_set_bits;
  reg  [1:0]  irq_stat_next;
  reg  [31:0] rdata_next;
  reg  [1:0]  rresp_next;

  // A held convert level must start only once, so starts are taken on its rising edge.

  assign selected  = !chip_sel_n && chip_en;
  assign start_cmd = selected && !read_conv && !selected_d_reg;
  assign read_cmd  = selected && read_conv;
  assign trial_done = conversion_busy_flag && (wait_cnt_reg == 16'h0000);
  assign conv_end   = trial_done && (bit_idx_reg == last_idx_reg);

  always @(posedge aclk) begin
    if (!aresetn) begin
      selected_d_reg <= 1'b0;
    end else begin
      selected_d_reg <= selected && !read_conv;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      conversion_busy_flag <= 1'b0;
      trial_level          <= 12'h000;
      result_reg           <= 12'h000;
      bit_idx_reg          <= 4'hB;
      last_idx_reg         <= 4'h0;
      wait_cnt_reg         <= 16'h0000;
    end else if (start_cmd && !conversion_busy_flag) begin
      conversion_busy_flag <= 1'b1;
      trial_level          <= `SARBI_HALF_SCALE;
      bit_idx_reg          <= MSB_IDX;
      last_idx_reg         <= byte_short_cycle_sel ? LSB_SHORT : LSB_FULL;
      wait_cnt_reg         <= TRIAL_LAST[15:0];
    end else if (conversion_busy_flag) begin
      // Each trial waits out its settling time before the comparator is trusted.
      if (wait_cnt_reg != 16'h0000) begin
        wait_cnt_reg <= wait_cnt_reg - 16'h0001;
      end else begin
        trial_level <= settle_bit(trial_level, bit_idx_reg, comp_above);
        if (conv_end) begin
          conversion_busy_flag <= 1'b0;
          result_reg <= settle_bit(trial_level, bit_idx_reg, comp_above);
        end else begin
          bit_idx_reg  <= bit_idx_reg - 4'h1;
          trial_level[bit_idx_reg - 4'h1] <= 1'b1;
          wait_cnt_reg <= TRIAL_LAST[15:0];
        end
      end
    end
  end

  always @* begin
    if (word_mode_reg) begin
      out_value = result_reg;
    end else if (!byte_short_cycle_sel) begin
      out_value = {4'h0, result_reg[11:4]};
    end else begin
      out_value = {4'h0, result_reg[3:0], 4'h0};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      result_bus <= 12'h000;
    end else begin
      result_bus <= out_value;
    end
  end

  assign result_bus_oe = (read_cmd && !conversion_busy_flag) ?
                         (word_mode_reg ? 12'hFFF : 12'h0FF) : 12'h000;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  assign do_write = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held_reg || (s_axi_wvalid && s_axi_wready));
  assign s_axi_arready = !s_axi_rvalid;
  assign irq = |(irq_stat_reg & irq_en_reg);

  assign hit_ctrl    = reg_hit(wr_addr, `SARBI_OFF_CTRL);
  assign hit_irq_en  = reg_hit(wr_addr, `SARBI_OFF_IRQ_EN);
  assign hit_irq_clr = reg_hit(wr_addr, `SARBI_OFF_IRQ_CLR);

  assign irq_clr_bits = (do_write && wr_strb[0] && hit_irq_clr) ? wr_data[1:0] : 2'h0;
  assign irq_set_bits = {start_cmd && !conversion_busy_flag, conv_end};

  // An event in the same cycle as its clear wins, so no event is lost.
  always @* begin
    irq_stat_next = (irq_stat_reg & ~irq_clr_bits) | irq_set_bits;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Read data is decoded here and registered when the address is taken.
  always @* begin
    rdata_next = 32'h00000000;
    rresp_next = `SARBI_RESP_OKAY;
    if (reg_hit(s_axi_araddr, `SARBI_OFF_CTRL)) begin
      rdata_next = {31'h0, word_mode_reg};
    end else if (reg_hit(s_axi_araddr, `SARBI_OFF_STATUS)) begin
      rdata_next = {31'h0, conversion_busy_flag};
    end else if (reg_hit(s_axi_araddr, `SARBI_OFF_RESULT)) begin
      rdata_next = {20'h0, result_reg};
    end else if (reg_hit(s_axi_araddr, `SARBI_OFF_IRQ_STAT)) begin
      rdata_next = {30'h0, irq_stat_reg};
    end else if (reg_hit(s_axi_araddr, `SARBI_OFF_IRQ_EN)) begin
      rdata_next = {30'h0, irq_en_reg};
    end else if (reg_hit(s_axi_araddr, `SARBI_OFF_IRQ_CLR)) begin
      rdata_next = 32'h00000000;
    end else begin
      rresp_next = `SARBI_RESP_SLVERR;
    end
  end

  // Address and data may arrive in either order; each is held until its partner comes.

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 5'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SARBI_RESP_OKAY;
      word_mode_reg <= `SARBI_CTRL_RESET;
      irq_en_reg    <= 2'h0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SARBI_RESP_OKAY;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          awaddr_reg  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          wdata_reg  <= s_axi_wdata;
          wstrb_reg  <= s_axi_wstrb;
        end
      end
      if (do_write && wr_strb[0] && hit_ctrl) begin
        word_mode_reg <= wr_data[`SARBI_CTRL_STRAP];
      end else if (do_write && wr_strb[0] && hit_irq_en) begin
        irq_en_reg <= wr_data[1:0];
      end else if (do_write && !hit_ctrl && !hit_irq_en && !hit_irq_clr) begin
        s_axi_bresp <= `SARBI_RESP_SLVERR;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SARBI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rresp_next;
      s_axi_rdata  <= rdata_next;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== testbench/sarbi_props.sv ====
// Timing and output checks on the converter's host pins.
module sarbi_props #(parameter TRIAL_CYC = 5) (
  input wire        aclk,
  input wire        aresetn,
  input wire        chip_sel_n,
  input wire        chip_en,
  input wire        read_conv,
  input wire        byte_short_cycle_sel,
  input wire [11:0] trial_level,
  input wire [11:0] result_bus,
  input wire [11:0] result_bus_oe,
  input wire        conversion_busy_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  wire sel = !chip_sel_n && chip_en;
  wire busy = conversion_busy_flag;
  reg short_reg, prev_reg;
  reg [7:0] cnt_reg;
  always @(posedge aclk) begin
    prev_reg <= aresetn && sel && !read_conv;
    cnt_reg <= (aresetn && busy) ? cnt_reg + 8'h01 : 8'h00;
    if (sel && !read_conv && !prev_reg && !busy) short_reg <= byte_short_cycle_sel;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  float_a: assert property (!(sel && read_conv) |-> result_bus_oe == 12'h000)
    else $error("outputs driven while idle");
  desel_a: assert property (!sel && !busy |=> !busy)
    else $error("start while deselected");
  start_a: assert property (sel && !read_conv && !prev_reg && !busy |=> busy)
    else $error("start not taken");
  half_a: assert property ($rose(busy) |-> trial_level == 12'h800)
    else $error("trial not at half scale");
  length_a: assert property (
    $fell(busy) |-> cnt_reg == (short_reg ? 8 : 12) * TRIAL_CYC)
    else $error("wrong conversion length");
  busy_oe_a: assert property (busy |-> result_bus_oe == 12'h000)
    else $error("outputs driven while busy");
  low_byte_a: assert property (
    result_bus_oe == 12'h0FF && $past(result_bus_oe) == 12'h0FF
    && $past(byte_short_cycle_sel) |-> result_bus[3:0] == 4'h0)
    else $error("low byte tail not zero");
  hold_a: assert property (
    result_bus_oe == 12'hFFF && $past(result_bus_oe) == 12'hFFF |-> $stable(result_bus))
    else $error("latched word changed");
endmodule
bind sarbi_top sarbi_props #(.TRIAL_CYC(TRIAL_CYC)) props (.aclk(aclk), .aresetn(aresetn),
  .chip_sel_n(chip_sel_n), .chip_en(chip_en), .read_conv(read_conv),
  .byte_short_cycle_sel(byte_short_cycle_sel), .trial_level(trial_level),
  .result_bus(result_bus), .result_bus_oe(result_bus_oe),
  .conversion_busy_flag(conversion_busy_flag));

// ==== testbench/sarbi_analog.sv ====
// Analog front end model: comparator of the held input against the trial level.
module sarbi_analog (
  input  wire logic [11:0] trial_level,
  input  wire logic [11:0] vin,
  output logic             comp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  assign comp_above = vin > trial_level;
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the converter interface.
`include "sarbi_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, chip_sel_n = 1, chip_en = 0, read_conv = 1, s;
  logic byte_short_cycle_sel = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, comp_above, irq, conversion_busy_flag;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] vin = 0, v, trial_level, result_bus, result_bus_oe;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  int miscompares = 0, check_count = 0, cycles = 0, seed = 32'h6D3C;
  sarbi_top #(.TRIAL_CYC(1)) dut (.aclk, .aresetn, .chip_sel_n, .chip_en, .read_conv,
    .byte_short_cycle_sel, .comp_above, .trial_level, .result_bus, .result_bus_oe,
    .conversion_busy_flag, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sarbi_analog front (.trial_level, .vin, .comp_above);
  always #50 aclk = ~aclk;
  task give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [11:0] sar(input logic [11:0] x, input logic c);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 11; i >= (c ? 4 : 0); i--) begin
      r[i] = 1'b1;
      if (!(x > r)) r[i] = 1'b0;
    end
    return r;
  endfunction
  task axw(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rb = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task axr(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task conv(input logic [11:0] e, input logic w);
    read_conv <= 0;
    chip_sel_n <= 0;
    byte_short_cycle_sel <= s;
    @(posedge aclk) chip_en <= 1;
    @(posedge aclk) chip_en <= 0;
    @(posedge aclk) byte_short_cycle_sel <= !s;
    chip_en <= 1;
    @(posedge aclk) chip_en <= 0;
    while (conversion_busy_flag) @(posedge aclk);
    read_conv <= 1;
    byte_short_cycle_sel <= 0;
    chip_en <= 1;
    repeat (2) @(posedge aclk);
    chk("oe", w ? 12'hFFF : 12'h0FF, result_bus_oe);
    chk("high", w ? e : e[11:4], w ? result_bus : result_bus[7:0]);
    byte_short_cycle_sel <= 1;
    repeat (2) @(posedge aclk);
    chk("low", w ? e : {e[3:0], 4'h0}, w ? {4'hA, result_bus} & 16'h0FFF : result_bus[7:0]);
    chip_en <= 0;
    @(posedge aclk) chk("float", 0, result_bus_oe);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 5; i++) begin
      axr(5'(4 * i));
      chk("reset", 0, rd);
    end
    axr(5'h18);
    chk("unmapped", `SARBI_RESP_SLVERR, rr);
    axw(`SARBI_OFF_IRQ_EN, 1);
    chip_sel_n <= 1;
    read_conv <= 0;
    @(posedge aclk) chip_en <= 1;
    repeat (3) @(posedge aclk);
    chk("deselected", 0, conversion_busy_flag);
    chip_en <= 0;
    chip_sel_n <= 0;
    @(posedge aclk) chip_sel_n <= 1;
    @(posedge aclk) chip_sel_n <= 0;
    repeat (3) @(posedge aclk);
    chk("disabled", 0, conversion_busy_flag);
    for (int k = 0; k < 8; k++) begin
      v = k == 0 ? 12'h800 : k == 1 ? 12'hFFF : 12'($random(seed));
      s = k == 1 || ($random(seed) & 1);
      if (k == 6) axw(`SARBI_OFF_CTRL, 1);
      vin <= v;
      conv(sar(v, s), k >= 6);
      axr(`SARBI_OFF_RESULT);
      chk("result", sar(v, s), rd);
      axr(`SARBI_OFF_STATUS);
      chk("status", 0, rd);
      chk("irq", k == 0, irq);
      axr(`SARBI_OFF_IRQ_STAT);
      chk("events", 3, rd);
      axw(`SARBI_OFF_IRQ_CLR, 3);
      chk("clear resp", `SARBI_RESP_OKAY, rb);
      chk("cleared", 0, irq);
      if (k == 0) axw(`SARBI_OFF_IRQ_EN, 0);
    end
    axw(`SARBI_OFF_STATUS, 1);
    chk("ro write", `SARBI_RESP_SLVERR, rb);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    axr(`SARBI_OFF_CTRL);
    chk("ctrl after reset", `SARBI_CTRL_RESET, rd);
    give_verdict();
  end
endmodule
